//--- core/tlpic_pkg.sv
package tlpic_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NSRC = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam int CTRL_PME = 0;
   localparam int CTRL_GH = 1;
   localparam int CTRL_PL = 2;
   localparam logic [NSRC-1:0] PERIPH_MASK = 8'hf0;
   localparam logic [NSRC-1:0] FORCED_HIGH = 8'h01;
   localparam logic [NSRC-1:0] SRC_RESET = 8'h00;
   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW = 16'h0018;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      LVL_IDLE = 4'h1,
      LVL_LOW = 4'h2,
      LVL_HIGH = 4'h4,
      LVL_HIGH_OVER_LOW = 4'h8
   } tlpic_lvl_t;
   typedef struct packed {
      logic pme;
      logic gh;
      logic pl;
      logic [NSRC-1:0] flag;
      logic [NSRC-1:0] en;
      logic [NSRC-1:0] prio;
      tlpic_lvl_t lvl;
      logic req;
      logic req_high;
      logic [15:0] vec;
      logic aw_full;
      logic w_full;
      logic [ADDR_W-1:0] awaddr;
      logic [DATA_W-1:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
   } tlpic_state_t;
endpackage : tlpic_pkg

//--- core/tlpic_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module tlpic_top (
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic [tlpic_pkg::NSRC-1:0] EVENT_I,
   input wire logic IRQ_ACK_I,
   input wire logic RETURN_I,
   output logic IRQ_REQ_O,
   output logic IRQ_HIGH_O,
   output logic [15:0] IRQ_VECTOR_O,
   input wire logic [tlpic_pkg::ADDR_W-1:0] AXI_AWADDR_I,
   input wire logic AXI_AWVALID_I,
   output logic AXI_AWREADY_O,
   input wire logic [tlpic_pkg::DATA_W-1:0] AXI_WDATA_I,
   input wire logic [3:0] AXI_WSTRB_I,
   input wire logic AXI_WVALID_I,
   output logic AXI_WREADY_O,
   output logic [1:0] AXI_BRESP_O,
   output logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   input wire logic [tlpic_pkg::ADDR_W-1:0] AXI_ARADDR_I,
   input wire logic AXI_ARVALID_I,
   output logic AXI_ARREADY_O,
   output logic [tlpic_pkg::DATA_W-1:0] AXI_RDATA_O,
   output logic [1:0] AXI_RRESP_O,
   output logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I
);
   import tlpic_pkg::*;

   tlpic_state_t s;
   tlpic_state_t next_s;
   logic [NSRC-1:0] active;
   logic [NSRC-1:0] prio_eff;
   logic hi_any;
   logic lo_any;
   logic take;
   logic wr_go;
   logic [DATA_W-1:0] rd_val;
   logic rd_hit;

   // pin zero forced high
   // fixed high priority
   assign prio_eff = s.prio | FORCED_HIGH;
   assign active = s.flag & s.en;

   // request qualification
   always_comb begin
      hi_any = 1'b0;
      lo_any = 1'b0;
      if (s.pme) begin
         hi_any = (|(active & prio_eff)) & s.gh;
         lo_any = (|(active & ~prio_eff)) & s.gh & s.pl;
      end else begin
         hi_any = (|(active & (~PERIPH_MASK | {NSRC{s.pl}}))) & s.gh;
      end
   end

   assign take = IRQ_ACK_I & s.req;
   assign wr_go = s.aw_full & s.w_full & ~s.bvalid;

   // read decode
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      if (AXI_ARADDR_I == OFS_CTRL) begin
         rd_val[CTRL_PME] = s.pme;
         rd_val[CTRL_GH] = s.gh;
         rd_val[CTRL_PL] = s.pl;
      end else if (AXI_ARADDR_I == OFS_FLAG) begin
         rd_val[NSRC-1:0] = s.flag;
      end else if (AXI_ARADDR_I == OFS_ENABLE) begin
         rd_val[NSRC-1:0] = s.en;
      end else if (AXI_ARADDR_I == OFS_PRIO) begin
         rd_val[NSRC-1:0] = prio_eff;
      end else if (AXI_ARADDR_I == OFS_STATUS) begin
         rd_val[7:0] = {s.lvl, 2'h0, s.req_high, s.req};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_comb begin
      next_s = s;
      // bus channels
      if (AXI_AWVALID_I && !s.aw_full) begin
         next_s.aw_full = 1'b1;
         next_s.awaddr = AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && !s.w_full) begin
         next_s.w_full = 1'b1;
         next_s.wdata = AXI_WDATA_I;
         next_s.wstrb0 = AXI_WSTRB_I[0];
      end
      if (s.bvalid && AXI_BREADY_I) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (s.awaddr == OFS_CTRL) begin
            if (s.wstrb0) begin
               next_s.pme = s.wdata[CTRL_PME];
               next_s.gh = s.wdata[CTRL_GH];
               next_s.pl = s.wdata[CTRL_PL];
            end
         end else if (s.awaddr == OFS_FLAG) begin
            if (s.wstrb0) begin
               next_s.flag = s.flag & ~s.wdata[NSRC-1:0];
            end
         end else if (s.awaddr == OFS_ENABLE) begin
            if (s.wstrb0) begin
               next_s.en = s.wdata[NSRC-1:0];
            end
         end else if (s.awaddr == OFS_PRIO) begin
            if (s.wstrb0) begin
               next_s.prio = s.wdata[NSRC-1:0];
            end
         end else if (s.awaddr == OFS_STATUS) begin
            next_s.bresp = RESP_OKAY;
         end else begin
            next_s.bresp = RESP_SLVERR;
         end
      end
      if (s.rvalid && AXI_RREADY_I) begin
         next_s.rvalid = 1'b0;
      end
      if (AXI_ARVALID_I && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_val;
         next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // accept by the core
      if (take) begin
         if (s.req_high) begin
            next_s.gh = 1'b0;
         end else begin
            next_s.pl = 1'b0;
         end
         case (s.lvl)
            LVL_IDLE: begin
               next_s.lvl = s.req_high ? LVL_HIGH : LVL_LOW;
            end
            LVL_LOW: begin
               next_s.lvl = s.req_high ? LVL_HIGH_OVER_LOW : LVL_LOW;
            end
            default: begin
               next_s.lvl = s.lvl;
            end
         endcase
      end
      // return from handler
      if (RETURN_I) begin
         case (s.lvl)
            LVL_HIGH: begin
               next_s.gh = 1'b1;
               next_s.lvl = LVL_IDLE;
            end
            LVL_HIGH_OVER_LOW: begin
               next_s.gh = 1'b1;
               next_s.lvl = LVL_LOW;
            end
            LVL_LOW: begin
               next_s.pl = 1'b1;
               next_s.lvl = LVL_IDLE;
            end
            default: begin
               next_s.gh = 1'b1;
            end
         endcase
      end
      next_s.flag = next_s.flag | EVENT_I;
      next_s.req = (hi_any | lo_any) & ~take;
      next_s.req_high = hi_any | ~s.pme;
      next_s.vec = (hi_any | ~s.pme) ? VEC_HIGH : VEC_LOW;
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s <= '0;
         s.lvl <= LVL_IDLE;
         s.vec <= VEC_HIGH;
      end else begin
         s <= next_s;
      end
   end

   assign IRQ_REQ_O = s.req;
   assign IRQ_HIGH_O = s.req_high;
   assign IRQ_VECTOR_O = s.vec;
   assign AXI_AWREADY_O = ~s.aw_full;
   assign AXI_WREADY_O = ~s.w_full;
   assign AXI_BVALID_O = s.bvalid;
   assign AXI_BRESP_O = s.bresp;
   assign AXI_ARREADY_O = ~s.rvalid;
   assign AXI_RVALID_O = s.rvalid;
   assign AXI_RRESP_O = s.rresp;
   assign AXI_RDATA_O = s.rdata;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   flag_set_a: assert property (
      EVENT_I != '0 |=> (s.flag & $past(EVENT_I)) == $past(EVENT_I))
      else $error("event did not set its flag");
   vec_compat_a: assert property (
      $rose(IRQ_REQ_O) && !$past(s.pme) |-> IRQ_VECTOR_O == VEC_HIGH)
      else $error("compat request not at high vector");
   vec_low_a: assert property (
      IRQ_REQ_O && !IRQ_HIGH_O |-> IRQ_VECTOR_O == VEC_LOW
         && $past(s.pme) && $past(s.pl))
      else $error("low request wrong vector or gating");
   ack_clear_a: assert property (
      take && s.req_high && !RETURN_I |=> !s.gh)
      else $error("accept left high enable set");
   ack_drop_a: assert property (
      take |=> !IRQ_REQ_O)
      else $error("request stayed after accept");
   ret_set_a: assert property (
      RETURN_I && s.lvl == LVL_HIGH_OVER_LOW |=> s.gh
         && s.lvl == LVL_LOW)
      else $error("return did not restore level");
   high_block_a: assert property (
      !s.gh |=> !IRQ_REQ_O)
      else $error("request with high enable clear");
   no_enable_a: assert property (
      active == '0 |=> !IRQ_REQ_O)
      else $error("request without enabled flag");
   high_first_a: assert property (
      $past((active & prio_eff) != '0 && s.gh) && IRQ_REQ_O
         |-> IRQ_HIGH_O && IRQ_VECTOR_O == VEC_HIGH)
      else $error("high source not served first");
   low_gate_a: assert property (
      IRQ_REQ_O && !IRQ_HIGH_O |-> $past(s.gh))
      else $error("low request with high enable clear");
   compat_high_a: assert property (
      !s.pme |=> IRQ_HIGH_O)
      else $error("compat request not marked high");
   periph_gate_a: assert property (
      !s.pme && !s.pl && (active & ~PERIPH_MASK) == '0 |=> !IRQ_REQ_O)
      else $error("peripheral request without its enable");
   pin_zero_a: assert property (
      s.pme && s.gh && (active & FORCED_HIGH) != '0 |=> IRQ_HIGH_O)
      else $error("pin irq zero not treated as high");
   ret_low_a: assert property (
      RETURN_I && s.lvl == LVL_LOW |=> s.pl && s.lvl == LVL_IDLE)
      else $error("return did not restore low enable");
   preempt_a: assert property (
      take && s.req_high && s.lvl == LVL_LOW && !RETURN_I
         |=> s.lvl == LVL_HIGH_OVER_LOW)
      else $error("high request did not pre-empt low");
   low_clear_a: assert property (
      take && !s.req_high && !RETURN_I |=> !s.pl)
      else $error("accept left low enable set");
   high_open_a: assert property (
      s.pme && s.gh && !take && (active & prio_eff) != '0
         |=> IRQ_REQ_O && IRQ_HIGH_O)
      else $error("enabled high source raised no request");

   preempt_c: cover property (
      s.lvl == LVL_LOW ##1 s.lvl == LVL_HIGH_OVER_LOW);
   low_take_c: cover property (take && !s.req_high);
   compat_take_c: cover property (take && !s.pme);
   both_elig_c: cover property (hi_any && lo_any);
   ret_low_c: cover property (RETURN_I && s.lvl == LVL_LOW);
endmodule : tlpic_top

//--- tb/tlpic_core_model.sv
module tlpic_core_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic [15:0] vec_i,
   input wire logic [1:0] wait_i,
   output logic ack_o,
   output logic [15:0] pc_o,
   output logic [7:0] taken_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         cnt <= 2'h0;
         pc_o <= 16'h0000;
         taken_o <= 8'h00;
      end else if (ack_o) begin
         ack_o <= 1'b0;
         cnt <= 2'h0;
         if (req_i) begin
            pc_o <= vec_i;
            taken_o <= taken_o + 8'h01;
         end
      end else if (req_i) begin
         if (cnt == wait_i)
            ack_o <= 1'b1;
         else
            cnt <= cnt + 2'h1;
      end
   end
endmodule : tlpic_core_model

//--- tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import tlpic_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] ev = 8'h00;
   logic ret = 1'b0;
   logic [1:0] slow = 2'h0;
   logic ack, req, hi;
   logic [15:0] vec, pc;
   logic [7:0] taken;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bq = 1'b0;
   logic arv = 1'b0;
   logic rq = 1'b0;
   logic [3:0] ws = 4'hf;
   logic awr, wr_r, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   int miscompares = 0;
   int samples_checked = 0;
   tlpic_top u_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .EVENT_I(ev),
      .IRQ_ACK_I(ack), .RETURN_I(ret), .IRQ_REQ_O(req), .IRQ_HIGH_O(hi),
      .IRQ_VECTOR_O(vec), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv),
      .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
      .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_r), .AXI_BRESP_O(br),
      .AXI_BVALID_O(bv), .AXI_BREADY_I(bq), .AXI_ARADDR_I(ara),
      .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat),
      .AXI_RRESP_O(rr), .AXI_RVALID_O(rv), .AXI_RREADY_I(rq));
   tlpic_core_model u_core (.clk_i(clk), .rstn_i(rstn), .req_i(req),
      .vec_i(vec), .wait_i(slow), .ack_o(ack), .pc_o(pc), .taken_o(taken));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   function automatic logic [1:0] resp_of(input logic [7:0] a);
      return (a > OFS_STATUS) ? RESP_SLVERR : RESP_OKAY;
   endfunction : resp_of
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bq <= 1'b1;
      do begin
         @(posedge clk);
         if (awr)
            awv <= 1'b0;
         if (wr_r)
            wv <= 1'b0;
      end while (bv !== 1'b1);
      chk({30'h0, br}, {30'h0, resp_of(a)});
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      ara <= a;
      arv <= 1'b1;
      rq <= 1'b1;
      do begin
         @(posedge clk);
         if (arr)
            arv <= 1'b0;
      end while (rv !== 1'b1);
      chk(rdat, e);
      chk({30'h0, rr}, {30'h0, resp_of(a)});
   endtask : rc
   task automatic fire(input logic [7:0] b);
      ev <= b;
      @(posedge clk);
      ev <= 8'h00;
      repeat (10) @(posedge clk);
   endtask : fire
   task automatic back;
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      @(posedge clk);
   endtask : back
   task automatic took(input logic [7:0] n, input logic [15:0] v);
      chk({24'h0, taken}, {24'h0, n});
      chk({16'h0, pc}, {16'h0, v});
      chk({31'h0, req}, 32'h0);
   endtask : took
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rc(OFS_CTRL, 32'h0);
      rc(OFS_ENABLE, 32'h0);
      rc(OFS_PRIO, 32'h1);
      rc(OFS_STATUS, 32'h12);
      chk({31'h0, hi}, 32'h1);
      rc(8'h14, 32'h0);
      ws <= 4'he;
      wr(OFS_ENABLE, 32'hff);
      ws <= 4'hf;
      rc(OFS_ENABLE, 32'h0);
      fire(8'h04);
      rc(OFS_FLAG, 32'h4);
      chk({24'h0, taken}, 32'h0);
      wr(OFS_FLAG, 32'hff);
      rc(OFS_FLAG, 32'h0);
      $display("reset and flags test done");
      wr(OFS_ENABLE, 32'hfd);
      wr(OFS_CTRL, 32'h2);
      fire(8'h12);
      chk({24'h0, taken}, 32'h0);
      wr(OFS_FLAG, 32'hff);
      fire(8'h08);
      took(8'h1, VEC_HIGH);
      rc(OFS_CTRL, 32'h0);
      wr(OFS_FLAG, 32'hff);
      back();
      rc(OFS_CTRL, 32'h2);
      wr(OFS_CTRL, 32'h6);
      fire(8'h10);
      took(8'h2, VEC_HIGH);
      wr(OFS_FLAG, 32'hff);
      back();
      $display("compatibility test done");
      slow <= 2'h2;
      wr(OFS_ENABLE, 32'hff);
      wr(OFS_CTRL, 32'h7);
      fire(8'h20);
      took(8'h3, VEC_LOW);
      rc(OFS_STATUS, 32'h20);
      chk({31'h0, hi}, 32'h0);
      fire(8'h01);
      took(8'h4, VEC_HIGH);
      rc(OFS_STATUS, 32'h80);
      wr(OFS_FLAG, 32'hff);
      back();
      back();
      rc(OFS_CTRL, 32'h7);
      rc(OFS_STATUS, 32'h10);
      wr(OFS_CTRL, 32'h5);
      fire(8'h20);
      chk({24'h0, taken}, 32'h4);
      wr(OFS_FLAG, 32'hff);
      wr(OFS_CTRL, 32'h3);
      wr(OFS_PRIO, 32'h40);
      fire(8'h60);
      took(8'h5, VEC_HIGH);
      wr(OFS_FLAG, 32'h40);
      back();
      wr(OFS_CTRL, 32'h5);
      fire(8'h01);
      wr(OFS_CTRL, 32'h7);
      fire(8'h00);
      took(8'h6, VEC_HIGH);
      rc(OFS_FLAG, 32'h21);
      wr(OFS_FLAG, 32'h01);
      back();
      fire(8'h00);
      took(8'h7, VEC_LOW);
      $display("priority test done");
      end_of_test();
   end
endmodule : tb_top
